//--- design/dcewk_baud_gen.sv
/*
 * Rate generator: sixteen-times oversample tick and bit tick for the
 * selected rate. Assumes clk at 100 MHz and a synchronous rate select.
 */
`include "dcewk_defines.svh"
module dcewk_baud_gen
    import dcewk_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [3:0] rate_sel,
    dcewk_baud_if.gen bif
);
    function automatic logic [31:0] rate_bps(input logic [3:0] s);
        case (s)
            4'h0: rate_bps = 32'd300;
            4'h1: rate_bps = 32'd600;
            4'h2: rate_bps = 32'd1200;
            4'h3: rate_bps = 32'd2400;
            4'h4: rate_bps = 32'd4800;
            4'h5: rate_bps = 32'd9600;
            4'h6: rate_bps = 32'd19200;
            4'h7: rate_bps = 32'd38400;
            4'h8: rate_bps = 32'd57600;
            4'h9: rate_bps = 32'd115200;
            4'ha: rate_bps = 32'd230400;
            4'hb: rate_bps = 32'd460800;
            4'hc: rate_bps = 32'd921600;
            4'hd: rate_bps = 32'd3200000;
            4'he: rate_bps = 32'd3686400;
            default: rate_bps = 32'd4000000;
        endcase
    endfunction : rate_bps

    // Fractional accumulator keeps the mean tick rate exact at every setting.
    logic [31:0] acc_q;
    logic [32:0] sum;
    logic [3:0] sub_q;
    logic [31:0] step;
    assign step = rate_bps(rate_sel) * 32'd16;
    assign sum = {1'b0, acc_q} + {1'b0, step};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_q <= 32'h0;
        end else if (clk_en) begin
            if (sum >= 33'(`DCEWK_CLK_HZ)) begin
                acc_q <= 32'(sum - 33'(`DCEWK_CLK_HZ));
            end else begin
                acc_q <= sum[31:0];
            end
        end
    end

    assign bif.tick16 = clk_en && (sum >= 33'(`DCEWK_CLK_HZ)); // see R2

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sub_q <= 4'h0;
        end else if (bif.tick16) begin
            sub_q <= sub_q + 4'h1;
        end
    end

    assign bif.tick1 = bif.tick16 && (sub_q == 4'hf);
endmodule : dcewk_baud_gen

//--- design/dcewk_baud_if.sv
/*
 * Carries the bit-rate tick and the oversampled tick between the rate
 * generator and the serial engine. Assumes a single clock domain.
 */
interface dcewk_baud_if;
    logic tick16;
    logic tick1;
    modport gen (output tick16, output tick1);
    modport use_p (input tick16, input tick1);
endinterface : dcewk_baud_if

//--- design/dcewk_defines.svh
/*
 * Constants for the host serial port with ring indication and DTR wake.
 * Assumes a 100 MHz core clock; included by the rate generator and the port module.
 */
`ifndef DCEWK_DEFINES_SVH
`define DCEWK_DEFINES_SVH

`define DCEWK_CLK_HZ 100000000
`define DCEWK_RATE_CNT 16
`define DCEWK_RATE_DEFAULT 4'h9
`define DCEWK_RING_LOW_MS 5900
`define DCEWK_RING_HIGH_MS 100
`define DCEWK_CYC_PER_MS (`DCEWK_CLK_HZ / 1000)
`define DCEWK_EVT_PULSE_MS 1
`define DCEWK_DATA_BITS 8

`endif

//--- design/dcewk_pkg.sv
/*
 * Types shared by the serial port modules.
 * Assumes the defines header is on the include path.
 */
package dcewk_pkg;
    typedef enum logic [1:0] {RI_IDLE, RI_EVENT, RI_RING_LOW, RI_RING_HIGH} dcewk_ri_state_t;
    typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_STOP} dcewk_ser_state_t;
endpackage : dcewk_pkg

//--- design/dcewk_uart.sv
/*
 * Host-facing seven-wire serial port, DCE role, with ring indication and
 * DTR wake. Assumes one 100 MHz clock, pins arrive asynchronous to it.
 */
// Overview of operation
// R1 - The device is a seven-wire asynchronous DCE port carrying AT commands and data.
// R2 - The port runs at one of sixteen listed rates from 300 to 4000000 bits per second.
// R3 - From reset until a change is asked for, the rate is 115200 bits per second.
// R4 - Ring output idles high and goes low on a short message or unsolicited report.
// R5 - On a voice call the ring output repeats 5900 ms low then 100 ms high.
// R6 - The ring waveform repeats until answer or hang-up, then the output returns high.
// R7 - While asleep, a low DTR input from the host wakes the device.
// R8 - A message or report indication ends after a fixed, configurable pulse length.
`include "dcewk_defines.svh"
module dcewk_uart
    import dcewk_pkg::*;
#(
    parameter int unsigned RING_LOW_CYC = `DCEWK_RING_LOW_MS * `DCEWK_CYC_PER_MS,
    parameter int unsigned RING_HIGH_CYC = `DCEWK_RING_HIGH_MS * `DCEWK_CYC_PER_MS,
    parameter int unsigned EVT_PULSE_CYC = `DCEWK_EVT_PULSE_MS * `DCEWK_CYC_PER_MS
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic rate_wr,
    input wire logic [3:0] rate_wdata,
    output logic [3:0] rate_cur,
    input wire logic txd_pin,
    output logic rxd_pin,
    input wire logic rts_n_pin,
    output logic cts_n_pin,
    input wire logic dtr_n_pin,
    output logic dcd_n_pin,
    output logic ri_n_pin,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_frame_err,
    input wire logic rx_stall,
    input wire logic carrier_on,
    input wire logic sms_event,
    input wire logic unsolicited_report,
    input wire logic call_ring,
    input wire logic sleep_active,
    output logic wake_req
);
    logic [3:0] rate_q;
    dcewk_baud_if bif ();

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rate_q <= `DCEWK_RATE_DEFAULT; // see R3
        end else if (clk_en && rate_wr) begin
            rate_q <= rate_wdata; // see R2
        end
    end
    assign rate_cur = rate_q;

    dcewk_baud_gen u_baud (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .rate_sel(rate_q),
        .bif(bif)
    );

    // Two-stage synchronisers for host-driven pins.
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= 3'h7;
            s2_q <= 3'h7;
        end else if (clk_en) begin
            s1_q <= {dtr_n_pin, rts_n_pin, txd_pin};
            s2_q <= s1_q;
        end
    end
    logic txd_s;
    logic rts_n_s;
    logic dtr_n_s;
    assign txd_s = s2_q[0];
    assign rts_n_s = s2_q[1];
    assign dtr_n_s = s2_q[2];

    // Transmit toward the host, held off while the host deasserts RTS.
    dcewk_ser_state_t ts_q;
    logic [7:0] tsh_q;
    logic [2:0] tbit_q;
    logic rxd_q;
    assign tx_ready = clk_en && (ts_q == SER_IDLE) && !rts_n_s;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ts_q <= SER_IDLE;
            tsh_q <= 8'h0;
            tbit_q <= 3'h0;
            rxd_q <= 1'b1;
        end else if (clk_en) begin
            case (ts_q)
                SER_IDLE: begin
                    if (tx_valid && tx_ready) begin // see R1
                        tsh_q <= tx_data;
                        ts_q <= SER_START;
                    end
                end
                SER_START: begin
                    if (bif.tick1) begin
                        rxd_q <= 1'b0;
                        tbit_q <= 3'h0;
                        ts_q <= SER_DATA;
                    end
                end
                SER_DATA: begin
                    if (bif.tick1) begin
                        rxd_q <= tsh_q[0];
                        tsh_q <= {1'b0, tsh_q[7:1]};
                        tbit_q <= tbit_q + 3'h1;
                        if (tbit_q == 3'h7) begin
                            ts_q <= SER_STOP;
                        end
                    end
                end
                default: begin
                    if (bif.tick1) begin
                        rxd_q <= 1'b1;
                        ts_q <= SER_IDLE;
                    end
                end
            endcase
        end
    end
    assign rxd_pin = rxd_q;

    // Receive from the host, sampled at mid-bit on the oversample tick.
    dcewk_ser_state_t rs_q;
    logic [3:0] rph_q;
    logic [2:0] rbit_q;
    logic [7:0] rsh_q;
    logic [7:0] rdat_q;
    logic rvld_q;
    logic rerr_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rs_q <= SER_IDLE;
            rph_q <= 4'h0;
            rbit_q <= 3'h0;
            rsh_q <= 8'h0;
            rdat_q <= 8'h0;
            rvld_q <= 1'b0;
            rerr_q <= 1'b0;
        end else if (clk_en) begin
            rvld_q <= 1'b0;
            case (rs_q)
                SER_IDLE: begin
                    if (!txd_s) begin
                        rph_q <= 4'h0;
                        rs_q <= SER_START;
                    end
                end
                SER_START: begin
                    if (bif.tick16) begin
                        rph_q <= rph_q + 4'h1;
                        if (rph_q == 4'h7) begin
                            rph_q <= 4'h0;
                            rbit_q <= 3'h0;
                            rs_q <= txd_s ? SER_IDLE : SER_DATA;
                        end
                    end
                end
                SER_DATA: begin
                    if (bif.tick16) begin
                        rph_q <= rph_q + 4'h1;
                        if (rph_q == 4'hf) begin
                            rsh_q <= {txd_s, rsh_q[7:1]};
                            rbit_q <= rbit_q + 3'h1;
                            if (rbit_q == 3'h7) begin
                                rs_q <= SER_STOP;
                            end
                        end
                    end
                end
                default: begin
                    if (bif.tick16) begin
                        rph_q <= rph_q + 4'h1;
                        if (rph_q == 4'hf) begin
                            rdat_q <= rsh_q; // see R1
                            rvld_q <= 1'b1;
                            rerr_q <= !txd_s;
                            rs_q <= SER_IDLE;
                        end
                    end
                end
            endcase
        end
    end
    assign rx_valid = rvld_q;
    assign rx_data = rdat_q;
    assign rx_frame_err = rerr_q;

    logic cts_q;
    logic dcd_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cts_q <= 1'b1;
            dcd_q <= 1'b1;
        end else if (clk_en) begin
            cts_q <= rx_stall; // see R1
            dcd_q <= !carrier_on;
        end
    end
    assign cts_n_pin = cts_q;
    assign dcd_n_pin = dcd_q;

    // Ring indicator: a voice call outranks a message pulse.
    dcewk_ri_state_t ri_q;
    logic [31:0] ricnt_q;
    logic ri_n_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ri_q <= RI_IDLE;
            ricnt_q <= 32'h0;
            ri_n_q <= 1'b1;
        end else if (clk_en) begin
            case (ri_q)
                RI_IDLE: begin
                    ri_n_q <= 1'b1;
                    ricnt_q <= 32'h0;
                    if (call_ring) begin
                        ri_n_q <= 1'b0;
                        ri_q <= RI_RING_LOW; // see R5
                    end else if (sms_event || unsolicited_report) begin
                        ri_n_q <= 1'b0;
                        ri_q <= RI_EVENT; // see R4
                    end
                end
                RI_EVENT: begin
                    ricnt_q <= ricnt_q + 32'h1;
                    if (call_ring) begin
                        ricnt_q <= 32'h0;
                        ri_q <= RI_RING_LOW;
                    end else if (ricnt_q == 32'(EVT_PULSE_CYC - 1)) begin
                        ri_n_q <= 1'b1; // see R8
                        ri_q <= RI_IDLE;
                    end
                end
                RI_RING_LOW: begin
                    ricnt_q <= ricnt_q + 32'h1;
                    if (!call_ring) begin
                        ri_n_q <= 1'b1; // see R6
                        ri_q <= RI_IDLE;
                    end else if (ricnt_q == 32'(RING_LOW_CYC - 1)) begin
                        ricnt_q <= 32'h0;
                        ri_n_q <= 1'b1; // see R5
                        ri_q <= RI_RING_HIGH;
                    end
                end
                default: begin
                    ricnt_q <= ricnt_q + 32'h1;
                    if (!call_ring) begin
                        ri_q <= RI_IDLE; // see R6
                    end else if (ricnt_q == 32'(RING_HIGH_CYC - 1)) begin
                        ricnt_q <= 32'h0;
                        ri_n_q <= 1'b0;
                        ri_q <= RI_RING_LOW;
                    end
                end
            endcase
        end
    end
    assign ri_n_pin = ri_n_q;

    logic wake_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_q <= 1'b0;
        end else if (clk_en) begin
            wake_q <= sleep_active && !dtr_n_s; // see R7
        end
    end
    assign wake_req = wake_q;

    chk_rate_reset: assert property (@(posedge clk) $rose(arst_n) |-> rate_q == 4'h9) // see R3
        else $error("rate not at default after reset");
    chk_ri_idle_high: assert property (@(posedge clk) disable iff (!arst_n)
        (ri_q == RI_IDLE && clk_en && !call_ring && !sms_event && !unsolicited_report)
        |=> ri_n_pin) // see R4
        else $error("ring output not high while idle");
    chk_ri_event_low: assert property (@(posedge clk) disable iff (!arst_n)
        (ri_q == RI_IDLE && clk_en && (sms_event || unsolicited_report)) |=> !ri_n_pin) // see R4
        else $error("ring output not low on message event");
    chk_ri_call_low: assert property (@(posedge clk) disable iff (!arst_n)
        (ri_q == RI_IDLE && clk_en && call_ring) |=> !ri_n_pin ##0 ri_q == RI_RING_LOW) // see R5
        else $error("ring output not low on call");
    chk_ring_low_len: assert property (@(posedge clk) disable iff (!arst_n)
        (ri_q == RI_RING_LOW) |-> ricnt_q < 32'(RING_LOW_CYC)) // see R5
        else $error("ring low phase overran");
    chk_ring_high_len: assert property (@(posedge clk) disable iff (!arst_n)
        (ri_q == RI_RING_HIGH) |-> ri_n_pin && ricnt_q < 32'(RING_HIGH_CYC)) // see R5
        else $error("ring high phase wrong");
    chk_ring_stop: assert property (@(posedge clk) disable iff (!arst_n)
        (ri_q == RI_RING_LOW && clk_en && !call_ring) |=> ri_n_pin && ri_q == RI_IDLE) // see R6
        else $error("ring output not released after call ends");
    chk_evt_release: assert property (@(posedge clk) disable iff (!arst_n)
        (ri_q == RI_EVENT) |-> ricnt_q < 32'(EVT_PULSE_CYC)) // see R8
        else $error("event pulse overran");
    chk_dtr_wake: assert property (@(posedge clk) disable iff (!arst_n)
        (clk_en && sleep_active && !dtr_n_s) |=> wake_req) // see R7
        else $error("no wake on low DTR");
    chk_tx_start: assert property (@(posedge clk) disable iff (!arst_n)
        (ts_q == SER_START && bif.tick1) |=> !rxd_pin) // see R1
        else $error("start bit missing");
    cov_call: cover property (@(posedge clk) ri_q == RI_RING_HIGH);
    cov_evt: cover property (@(posedge clk) ri_q == RI_EVENT ##1 ri_q == RI_IDLE);
    cov_rx: cover property (@(posedge clk) rx_valid && !rx_frame_err);
    cov_wake: cover property (@(posedge clk) wake_req);
endmodule : dcewk_uart

//--- test/dce_uart_ring_wake_tb.sv
/*
 * Testbench for the host serial port: frames both ways, rates, ring, wake.
 * Assumes the design files and the host model are compiled before it.
 */
module dce_uart_ring_wake_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [3:0] sel; logic [7:0] d;} dcewk_row_t;
    localparam int LOW_C = 50;
    localparam int HIGH_C = 10;
    localparam int EVT_C = 8;
    logic clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, rate_wr = 1'b0, txd_pin;
    logic rts_n_pin = 1'b0, dtr_n_pin = 1'b1, tx_valid = 1'b0, rx_stall = 1'b0;
    logic carrier_on = 1'b0, sms_event = 1'b0, unsolicited_report = 1'b0;
    logic call_ring = 1'b0, sleep_active = 1'b0;
    logic [3:0] rate_wdata = 4'h0;
    logic [7:0] tx_data = 8'h00;
    logic [3:0] rate_cur;
    logic [7:0] rx_data;
    logic rxd_pin, cts_n_pin, dcd_n_pin, ri_n_pin, tx_ready, rx_valid, rx_frame_err, wake_req;
    int error_cnt = 0;
    int compares = 0;
    int n;
    int rates[16] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200,
        230400, 460800, 921600, 3200000, 3686400, 4000000};
    dcewk_row_t rows[4] = '{'{4'hc, 8'ha5}, '{4'hd, 8'h01}, '{4'he, 8'h80}, '{4'hf, 8'h5a}};

    dcewk_uart #(.RING_LOW_CYC(LOW_C), .RING_HIGH_CYC(HIGH_C), .EVT_PULSE_CYC(EVT_C))
    dcewk_uart_i (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .rate_wr(rate_wr),
        .rate_wdata(rate_wdata), .rate_cur(rate_cur), .txd_pin(txd_pin), .rxd_pin(rxd_pin),
        .rts_n_pin(rts_n_pin), .cts_n_pin(cts_n_pin), .dtr_n_pin(dtr_n_pin),
        .dcd_n_pin(dcd_n_pin), .ri_n_pin(ri_n_pin), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data), .rx_frame_err(rx_frame_err),
        .rx_stall(rx_stall), .carrier_on(carrier_on), .sms_event(sms_event),
        .unsolicited_report(unsolicited_report), .call_ring(call_ring),
        .sleep_active(sleep_active), .wake_req(wake_req));
    dcewk_host dcewk_host_i (.clk(clk), .rxd_pin(rxd_pin), .txd_pin(txd_pin));

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run

    task automatic set_rate(input logic [3:0] s);
        @(posedge clk);
        #1 rate_wr = 1'b1;
        rate_wdata = s;
        @(posedge clk);
        #1 rate_wr = 1'b0;
        dcewk_host_i.bit_cyc = 100000000 / rates[s];
        chk("rate_cur", {28'h0, rate_cur}, {28'h0, s});
    endtask : set_rate

    // Device sends a byte; the host model must decode it with a high stop bit.
    task automatic dev_tx(input logic [7:0] d);
        int c;
        c = dcewk_host_i.got_cnt;
        @(posedge clk);
        #1 tx_valid = 1'b1;
        tx_data = d;
        while (tx_ready !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1 tx_valid = 1'b0;
        for (int i = 0; i < 20000 && dcewk_host_i.got_cnt == c; i++) @(posedge clk);
        chk("host_frames", dcewk_host_i.got_cnt, c + 1);
        chk("host_byte", {24'h0, dcewk_host_i.got}, {24'h0, d});
        chk("host_stop", {31'h0, dcewk_host_i.got_stop}, 32'h1);
    endtask : dev_tx

    // Host sends a byte with the given stop bit; the device must report it, flagging a frame error when the stop bit is low.
    task automatic host_tx(input logic [7:0] d, input logic stop);
        int i;
        fork
            dcewk_host_i.send(d, stop);
        join_none
        for (i = 0; i < 20000 && rx_valid !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk("rx_valid", {31'h0, rx_valid}, 32'h1);
        chk("rx_data", {24'h0, rx_data}, {24'h0, d});
        chk("rx_frame_err", {31'h0, rx_frame_err}, {31'h0, ~stop});
        wait fork;
    endtask : host_tx

    task automatic run_len(input logic lvl, output int len);
        len = 0;
        while (ri_n_pin === lvl && len < 200) begin
            @(posedge clk);
            #1;
            len++;
        end
    endtask : run_len

    initial begin
        #600000;
        error_cnt++;
        $display("watchdog expired");
        complete_run();
    end

    initial begin
        repeat (10) @(posedge clk);
        chk("reset_pins", {28'h0, rxd_pin, ri_n_pin, cts_n_pin, dcd_n_pin}, 32'hf);
        chk("reset_rate", {28'h0, rate_cur}, 32'h9);
        #1 arst_n = 1'b1;
        dev_tx(8'h3c);
        $display("test reset and default rate done");
        foreach (rows[r]) begin
            set_rate(rows[r].sel);
            dev_tx(rows[r].d);
            host_tx(~rows[r].d, 1'b1);
        end
        $display("test row loop done");
        for (int s = 0; s < 16; s++) set_rate(s[3:0]);
        host_tx(8'h96, 1'b0);
        $display("test rates and framing error done");
        @(posedge clk);
        #1 rts_n_pin = 1'b1;
        repeat (4) @(posedge clk);
        #1 chk("tx_ready_rts", {31'h0, tx_ready}, 32'h0);
        rts_n_pin = 1'b0;
        repeat (4) @(posedge clk);
        #1 chk("tx_ready_free", {31'h0, tx_ready}, 32'h1);
        clk_en = 1'b0;
        rx_stall = 1'b1;
        carrier_on = 1'b1;
        #1 chk("tx_ready_en", {31'h0, tx_ready}, 32'h0);
        repeat (2) @(posedge clk);
        #1 chk("cts_dcd_frozen", {30'h0, cts_n_pin, dcd_n_pin}, 32'h1);
        clk_en = 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("cts_dcd", {30'h0, cts_n_pin, dcd_n_pin}, 32'h2);
        $display("test flow wires done");
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            #1 sms_event = (k == 0);
            unsolicited_report = (k == 1);
            @(posedge clk);
            #1 sms_event = 1'b0;
            unsolicited_report = 1'b0;
            chk("evt_low", {31'h0, ri_n_pin}, 32'h0);
            run_len(1'b0, n);
            chk("evt_len", {31'h0, n >= EVT_C - 1 && n <= EVT_C + 1}, 32'h1);
        end
        $display("test event pulses done");
        @(posedge clk);
        #1 call_ring = 1'b1;
        @(posedge clk);
        #1 chk("ring_start", {31'h0, ri_n_pin}, 32'h0);
        run_len(1'b0, n);
        chk("ring_low", {31'h0, n >= LOW_C - 1 && n <= LOW_C + 1}, 32'h1);
        run_len(1'b1, n);
        chk("ring_high", {31'h0, n >= HIGH_C - 1 && n <= HIGH_C + 1}, 32'h1);
        chk("ring_again", {31'h0, ri_n_pin}, 32'h0);
        call_ring = 1'b0;
        @(posedge clk);
        #1 chk("ring_end", {31'h0, ri_n_pin}, 32'h1);
        $display("test voice ring done");
        dtr_n_pin = 1'b0;
        repeat (5) @(posedge clk);
        #1 chk("wake_awake", {31'h0, wake_req}, 32'h0);
        sleep_active = 1'b1;
        repeat (5) @(posedge clk);
        #1 chk("wake_sleep", {31'h0, wake_req}, 32'h1);
        dtr_n_pin = 1'b1;
        repeat (5) @(posedge clk);
        #1 chk("wake_dtr_hi", {31'h0, wake_req}, 32'h0);
        $display("test dtr wake done");
        call_ring = 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("ring_pre_reset", {31'h0, ri_n_pin}, 32'h0);
        arst_n = 1'b0;
        #1 chk("mid_reset", {26'h0, rate_cur, ri_n_pin, wake_req}, {26'h0, 4'h9, 1'b1, 1'b0});
        call_ring = 1'b0;
        @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1 chk("after_reset", {30'h0, ri_n_pin, tx_ready}, 32'h3);
        $display("test mid run reset done");
        complete_run();
    end
endmodule : dce_uart_ring_wake_tb

//--- test/dcewk_host.sv
/*
 * Host-side model of the serial link: sends and decodes 8N1 frames.
 * Assumes the bench sets the bit length in clock cycles before use.
 */
module dcewk_host (
    input wire logic clk,
    input wire logic rxd_pin,
    output logic txd_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got = 8'h00;
    logic got_stop = 1'b0;
    int unsigned bit_cyc = 868;
    int unsigned got_cnt = 0;

    initial txd_pin = 1'b1;

    // Start bit, eight data bits least significant first, then the stop bit.
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            #1 txd_pin = f[i];
            repeat (bit_cyc - 1) @(posedge clk);
        end
        @(posedge clk);
        #1 txd_pin = 1'b1;
    endtask : send

    // Samples each bit in its middle at the rate the bench selected.
    always begin
        @(negedge rxd_pin);
        repeat (bit_cyc / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cyc) @(posedge clk);
            got[i] = rxd_pin;
        end
        repeat (bit_cyc) @(posedge clk);
        got_stop = rxd_pin;
        got_cnt++;
    end
endmodule : dcewk_host
